// ### hw/dlch_pkg.sv
// How it works
// - Transmit-active flag in bit 0, register 31
// - Link-up flag in bit 0, register 4
// - Requests start only while error count zero
// - Held configure waits for link up, no comm errors
// - Latched configure is sent when error resets
// - Other latched requests discarded when error resets
// - Register 14 counts every valid received message
// - Code C shown until link is established
// - Odd parity, checksum good before data stored
// - Valid message restarts receive timeout timer
package dlch_pkg;
	localparam int unsigned REG_W          = 16;
	localparam int unsigned PADDR_W        = 12;
	// Register indices; byte address is four times the index
	localparam logic [6:0]  IDX_LINK_UP    = 7'h04;
	localparam logic [6:0]  IDX_RX_COUNT   = 7'h0e;
	localparam logic [6:0]  IDX_COMM_ERR   = 7'h1a;
	localparam logic [6:0]  IDX_COMMAND    = 7'h1e;
	localparam logic [6:0]  IDX_TX_STATUS  = 7'h1f;
	localparam logic [6:0]  IDX_CFG_ERR    = 7'h20;
	localparam logic [6:0]  IDX_COMM_CLR   = 7'h21;
	localparam logic [6:0]  IDX_IN_INT     = 7'h46;
	localparam logic [6:0]  IDX_IN_BOOL    = 7'h47;
	localparam logic [6:0]  IDX_OUT_INT    = 7'h4b;
	localparam logic [6:0]  IDX_OUT_BOOL   = 7'h4c;
	localparam logic [6:0]  IDX_TIMING     = 7'h50;
	localparam logic [6:0]  IDX_SCAN       = 7'h51;
	// Field positions
	localparam int unsigned LINK_UP_BIT    = 0;
	localparam int unsigned TX_ACTIVE_BIT  = 0;
	// Command encodings
	localparam logic [15:0] CMD_MASK       = 16'h0086;
	localparam logic [15:0] CMD_CONFIG     = 16'h0001;
	// Reset values
	localparam logic [15:0] RST_ZERO       = 16'h0000;
	localparam logic [15:0] RST_TIMEOUT_MS = 16'h0064;
	localparam logic [15:0] RST_SCAN_MS    = 16'h0014;
	// Timeout tick of one millisecond
	localparam int unsigned CLK_PERIOD_NS  = 40;
	localparam int unsigned TICK_TIME_NS   = 1000000;
	localparam int unsigned TICK_CYCLES    = TICK_TIME_NS / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		CMD_IDLE = 2'b00,
		CMD_HOLD = 2'b01,
		CMD_SEND = 2'b10
	} dlch_cmd_state_type;

	function automatic logic [PADDR_W-1:0] reg_addr(input logic [6:0] idx);
		return {3'h0, idx, 2'h0};
	endfunction : reg_addr
endpackage : dlch_pkg

// ### hw/dlch_rx_check.sv
`timescale 1ns/1ps
module dlch_rx_check (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Received bytes
	input  wire logic       byte_valid,
	input  wire logic [7:0] byte_data,
	input  wire logic       byte_parity,
	input  wire logic       byte_frame_err,
	// End of message
	input  wire logic       msg_end,
	input  wire logic       cksum_a_ok,
	input  wire logic       cksum_b_ok,
	// Verdict
	output logic            msg_valid,
	output logic            msg_bad
);
	logic err_seen_reg;
	logic byte_err;

	assign byte_err = byte_valid & (byte_frame_err | ~(^{byte_data, byte_parity}));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			err_seen_reg <= 1'b0;
		end else if (msg_end) begin
			err_seen_reg <= 1'b0;
		end else if (byte_err) begin
			err_seen_reg <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msg_valid <= 1'b0;
			msg_bad   <= 1'b0;
		end else begin
			msg_valid <= msg_end & ~err_seen_reg & ~byte_err & (cksum_a_ok | cksum_b_ok);
			msg_bad   <= msg_end & (err_seen_reg | byte_err | ~(cksum_a_ok | cksum_b_ok));
		end
	end

	chk_parity_blocks: assert property (@(posedge pclk) disable iff (!presetn)
		(msg_end && (byte_err || err_seen_reg)) |=> (!msg_valid && msg_bad))
		else $error("Message with byte error was accepted");
endmodule : dlch_rx_check

// ### hw/dlch_rx_timeout.sv
`timescale 1ns/1ps
module dlch_rx_timeout #(
	parameter int unsigned TICK_CYCLES = dlch_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Control
	input  wire logic        run,
	input  wire logic        restart,
	input  wire logic [15:0] limit_ms,
	// Expiry
	output logic             expired
);
	logic [31:0] tick_reg;
	logic [15:0] ms_reg;
	logic        tick_end;

	assign tick_end = (tick_reg == 32'(TICK_CYCLES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_reg <= 32'h0000_0000;
			ms_reg   <= 16'h0000;
			expired  <= 1'b0;
		end else if (!run || restart) begin
			tick_reg <= 32'h0000_0000;
			ms_reg   <= 16'h0000;
			expired  <= 1'b0;
		end else if (tick_end) begin
			tick_reg <= 32'h0000_0000;
			expired  <= (ms_reg + 16'h0001 >= limit_ms);
			ms_reg   <= (ms_reg + 16'h0001 >= limit_ms) ? 16'h0000 : ms_reg + 16'h0001;
		end else begin
			tick_reg <= tick_reg + 32'h0000_0001;
			expired  <= 1'b0;
		end
	end

	chk_restart_clears: assert property (@(posedge pclk) disable iff (!presetn)
		(run && restart) |=> (tick_reg == 32'h0 && ms_reg == 16'h0 && !expired))
		else $error("Valid message did not restart timeout");
endmodule : dlch_rx_timeout

// ### hw/dlch_link_cmd.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
module dlch_link_cmd #(
	parameter int unsigned TICK_CYCLES = dlch_pkg::TICK_CYCLES
) (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	// Receiver side
	input  wire logic        rx_byte_valid,
	input  wire logic [7:0]  rx_byte,
	input  wire logic        rx_parity,
	input  wire logic        rx_frame_err,
	input  wire logic        rx_msg_end,
	input  wire logic        rx_cksum_a_ok,
	input  wire logic        rx_cksum_b_ok,
	output logic             rx_store_en,
	// Transmitter side
	input  wire logic        tx_done,
	input  wire logic        cfg_reject,
	output logic             tx_start,
	output logic [15:0]      tx_command,
	// Display
	output logic             fault_code_c
);
	localparam int unsigned NCFG = 6;

	dlch_pkg::dlch_cmd_state_type state_reg;
	dlch_pkg::dlch_cmd_state_type state_next;

	logic [15:0] cmd_reg;
	logic [15:0] rx_count_reg;
	logic [15:0] comm_err_reg;
	logic [15:0] comm_err_prev_reg;
	logic [15:0] cfg_err_reg;
	logic [15:0] cfg_reg [NCFG];
	logic        link_up_reg;
	logic        tx_active_reg;
	logic        msg_valid;
	logic        msg_bad;
	logic        timeout_pulse;
	logic        wr_en;
	logic        rd_en;
	logic        hit;
	logic [6:0]  idx;
	logic        host_cmd_wr;
	logic        comm_clr_wr;
	logic        err_bump;
	logic        err_reset_evt;
	logic        can_go;
	logic        discard;
	logic [31:0] rd_mux;

	function automatic logic [15:0] merge(input logic [15:0] old,
	                                      input logic [31:0] wd,
	                                      input logic [3:0]  st);
		return {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction : merge

	function automatic int cfg_slot(input logic [6:0] i);
		case (i)
			dlch_pkg::IDX_IN_INT:   return 0;
			dlch_pkg::IDX_IN_BOOL:  return 1;
			dlch_pkg::IDX_OUT_INT:  return 2;
			dlch_pkg::IDX_OUT_BOOL: return 3;
			dlch_pkg::IDX_TIMING:   return 4;
			dlch_pkg::IDX_SCAN:     return 5;
			default:                return -1;
		endcase
	endfunction : cfg_slot

	// Message check and receive timeout
	dlch_rx_check u_check (
		.pclk           (pclk),
		.presetn        (presetn),
		.byte_valid     (rx_byte_valid),
		.byte_data      (rx_byte),
		.byte_parity    (rx_parity),
		.byte_frame_err (rx_frame_err),
		.msg_end        (rx_msg_end),
		.cksum_a_ok     (rx_cksum_a_ok),
		.cksum_b_ok     (rx_cksum_b_ok),
		.msg_valid      (msg_valid),
		.msg_bad        (msg_bad)
	);

	dlch_rx_timeout #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_timeout (
		.pclk     (pclk),
		.presetn  (presetn),
		.run      (link_up_reg),
		.restart  (msg_valid),
		.limit_ms (cfg_reg[4]),
		.expired  (timeout_pulse)
	);

	assign rx_store_en = msg_valid;

	// APB decode
	assign idx     = paddr[8:2];
	assign hit     = (paddr[11:9] == 3'h0) && (paddr[1:0] == 2'h0) &&
	                 (idx == dlch_pkg::IDX_LINK_UP || idx == dlch_pkg::IDX_RX_COUNT ||
	                  idx == dlch_pkg::IDX_COMM_ERR || idx == dlch_pkg::IDX_COMMAND ||
	                  idx == dlch_pkg::IDX_TX_STATUS || idx == dlch_pkg::IDX_CFG_ERR ||
	                  idx == dlch_pkg::IDX_COMM_CLR || cfg_slot(idx) >= 0);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~hit;
	assign wr_en   = psel & penable & pwrite & hit;
	assign rd_en   = psel & ~penable & ~pwrite;
	assign host_cmd_wr = wr_en && idx == dlch_pkg::IDX_COMMAND && pstrb != 4'h0;
	assign comm_clr_wr = wr_en && idx == dlch_pkg::IDX_COMM_CLR && pstrb[0] && pwdata[0];

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit) begin
			case (idx)
				dlch_pkg::IDX_LINK_UP:   rd_mux[dlch_pkg::LINK_UP_BIT] = link_up_reg;
				dlch_pkg::IDX_RX_COUNT:  rd_mux[15:0] = rx_count_reg;
				dlch_pkg::IDX_COMM_ERR:  rd_mux[15:0] = comm_err_reg;
				dlch_pkg::IDX_COMMAND:   rd_mux[15:0] = cmd_reg;
				dlch_pkg::IDX_TX_STATUS: rd_mux[dlch_pkg::TX_ACTIVE_BIT] = tx_active_reg;
				dlch_pkg::IDX_CFG_ERR:   rd_mux[15:0] = cfg_err_reg;
				dlch_pkg::IDX_COMM_CLR:  rd_mux = 32'h0000_0000;
				default: begin
					if (cfg_slot(idx) >= 0) begin
						rd_mux[15:0] = cfg_reg[cfg_slot(idx)];
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata <= rd_mux;
		end
	end

	// Configuration registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < NCFG; i++) begin
				cfg_reg[i] <= dlch_pkg::RST_ZERO;
			end
			cfg_reg[4] <= dlch_pkg::RST_TIMEOUT_MS;
			cfg_reg[5] <= dlch_pkg::RST_SCAN_MS;
		end else if (wr_en && cfg_slot(idx) >= 0) begin
			cfg_reg[cfg_slot(idx)] <= merge(cfg_reg[cfg_slot(idx)], pwdata, pstrb);
		end
	end

	// Link state, set on a valid message, lost on timeout
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_up_reg <= 1'b0;
		end else if (msg_valid) begin
			link_up_reg <= 1'b1;
		end else if (timeout_pulse) begin
			link_up_reg <= 1'b0;
		end
	end

	assign fault_code_c = ~link_up_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_count_reg <= dlch_pkg::RST_ZERO;
		end else if (msg_valid) begin
			rx_count_reg <= rx_count_reg + 16'h0001;
		end
	end

	// Communication error count; an error with a clear loads one
	assign err_bump = msg_bad | timeout_pulse;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			comm_err_reg      <= dlch_pkg::RST_ZERO;
			comm_err_prev_reg <= dlch_pkg::RST_ZERO;
		end else begin
			comm_err_prev_reg <= comm_err_reg;
			if (err_bump && comm_clr_wr) begin
				comm_err_reg <= 16'h0001;
			end else if (err_bump && comm_err_reg != 16'hffff) begin
				comm_err_reg <= comm_err_reg + 16'h0001;
			end else if (comm_clr_wr) begin
				comm_err_reg <= dlch_pkg::RST_ZERO;
			end
		end
	end

	assign err_reset_evt = comm_err_prev_reg != 16'h0000 && comm_err_reg == 16'h0000;

	// Configuration error count; a reject beats a clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_err_reg <= dlch_pkg::RST_ZERO;
		end else if (cfg_reject && cfg_err_reg != 16'hffff) begin
			cfg_err_reg <= cfg_err_reg + 16'h0001;
		end else if (can_go && cmd_reg == dlch_pkg::CMD_CONFIG && !cfg_reject) begin
			cfg_err_reg <= dlch_pkg::RST_ZERO;
		end
	end

	// Request acceptance
	assign discard = err_reset_evt && cmd_reg != 16'h0000 &&
	                 cmd_reg != dlch_pkg::CMD_CONFIG;
	assign can_go  = state_reg != dlch_pkg::CMD_SEND && cmd_reg != 16'h0000 &&
	                 !host_cmd_wr && !discard && link_up_reg &&
	                 comm_err_reg == 16'h0000 &&
	                 (cfg_err_reg == 16'h0000 || cmd_reg == dlch_pkg::CMD_CONFIG);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			dlch_pkg::CMD_IDLE,
			dlch_pkg::CMD_HOLD: begin
				if (can_go) begin
					state_next = dlch_pkg::CMD_SEND;
				end else if (cmd_reg != 16'h0000 && !discard) begin
					state_next = dlch_pkg::CMD_HOLD;
				end else begin
					state_next = dlch_pkg::CMD_IDLE;
				end
			end
			dlch_pkg::CMD_SEND: begin
				if (tx_done) begin
					state_next = dlch_pkg::CMD_IDLE;
				end
			end
			default: state_next = dlch_pkg::CMD_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg     <= dlch_pkg::CMD_IDLE;
			tx_active_reg <= 1'b0;
		end else begin
			state_reg     <= state_next;
			tx_active_reg <= state_next == dlch_pkg::CMD_SEND;
		end
	end

	// Command word; a host write beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg <= dlch_pkg::RST_ZERO;
		end else if (host_cmd_wr) begin
			cmd_reg <= merge(cmd_reg, pwdata, pstrb);
		end else if (can_go || discard) begin
			cmd_reg <= dlch_pkg::RST_ZERO;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_start   <= 1'b0;
			tx_command <= dlch_pkg::RST_ZERO;
		end else begin
			tx_start <= can_go;
			if (can_go) begin
				tx_command <= cmd_reg;
			end
		end
	end

	chk_tx_flag_read: assert property (@(posedge pclk) disable iff (!presetn)
		(rd_en && hit && idx == dlch_pkg::IDX_TX_STATUS)
		|=> (prdata[0] == $past(tx_active_reg) && prdata[31:1] == 31'h0))
		else $error("Transmit flag read back wrong");

	chk_link_up_set: assert property (@(posedge pclk) disable iff (!presetn)
		msg_valid |=> link_up_reg ##0 !fault_code_c)
		else $error("Valid message did not raise link up");

	chk_start_clean: assert property (@(posedge pclk) disable iff (!presetn)
		tx_start |-> ($past(comm_err_reg) == 16'h0 && $past(link_up_reg)))
		else $error("Request started under error or link down");

	chk_cfg_only_held: assert property (@(posedge pclk) disable iff (!presetn)
		(tx_start && $past(cfg_err_reg) != 16'h0) |-> tx_command == dlch_pkg::CMD_CONFIG)
		else $error("Non-configure request sent under config errors");

	chk_cfg_after_err: assert property (@(posedge pclk) disable iff (!presetn)
		(err_reset_evt && cmd_reg == dlch_pkg::CMD_CONFIG && link_up_reg &&
		 state_reg != dlch_pkg::CMD_SEND && !host_cmd_wr)
		|=> (tx_start && tx_command == dlch_pkg::CMD_CONFIG && tx_active_reg))
		else $error("Latched configure not sent on error reset");

	chk_discard_other: assert property (@(posedge pclk) disable iff (!presetn)
		(discard && !host_cmd_wr) |=> (cmd_reg == 16'h0 && !tx_start))
		else $error("Latched request not discarded on error reset");

	chk_rx_count_inc: assert property (@(posedge pclk) disable iff (!presetn)
		msg_valid |=> rx_count_reg == 16'($past(rx_count_reg) + 16'h0001))
		else $error("Receive count did not advance");

	chk_fault_c_show: assert property (@(posedge pclk) disable iff (!presetn)
		(timeout_pulse && !msg_valid) |=> fault_code_c [*1])
		else $error("Code C not shown after link loss");

	chk_cmd_cleared: assert property (@(posedge pclk) disable iff (!presetn)
		(can_go && !host_cmd_wr) |=> (cmd_reg == 16'h0 ##1 tx_active_reg || tx_done))
		else $error("Command word not cleared on start");
endmodule : dlch_link_cmd

// ### tb/dlch_drive_model.sv
`timescale 1ns/1ps
module dlch_drive_model (
	// Clock and reset
	input  wire logic  pclk,
	input  wire logic  presetn,
	// From the module
	input  wire logic  tx_start,
	// To the module
	output logic       rx_byte_valid,
	output logic [7:0] rx_byte,
	output logic       rx_parity,
	output logic       rx_frame_err,
	output logic       rx_msg_end,
	output logic       rx_cksum_a_ok,
	output logic       rx_cksum_b_ok,
	output logic       tx_done,
	output logic       cfg_reject
);
	logic               fast_link_enable         = 1'b1;
	logic               alternate_network_enable = 1'b0;
	logic [7:0]         serial_port_usage        = 8'h00;
	logic signed [15:0] drive_tx_msg_count;
	logic [15:0]        drive_rx_msg_count;
	int unsigned        tx_delay                 = 40;
	int unsigned        cnt;
	logic               busy;
	logic               port_on;

	// Channel selected for this link only
	assign port_on = fast_link_enable && !alternate_network_enable
		&& serial_port_usage == 8'h00;

	initial begin
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		rx_parity = 1'b0;
		rx_frame_err = 1'b0;
		rx_msg_end = 1'b0;
		rx_cksum_a_ok = 1'b0;
		rx_cksum_b_ok = 1'b0;
		cfg_reject = 1'b0;
	end

	// Three bytes, odd parity unless spoiled, then message end
	task send_msg(input logic par_bad, input logic ck_bad,
		input logic fr_bad);
		logic [7:0] b;
		b = 8'h00;
		for (int i = 0; i < 3; i++) begin
			b = 8'h5a + 8'(i);
			rx_byte_valid <= port_on;
			rx_byte <= b;
			rx_parity <= (~^b) ^ (par_bad && i == 1);
			rx_frame_err <= fr_bad && i == 2;
			@(posedge pclk);
		end
		rx_byte_valid <= 1'b0;
		rx_frame_err <= 1'b0;
		rx_byte <= ~b;
		rx_parity <= ^b;
		rx_msg_end <= port_on;
		rx_cksum_a_ok <= !ck_bad;
		rx_cksum_b_ok <= !ck_bad;
		@(posedge pclk);
		rx_msg_end <= 1'b0;
		rx_cksum_a_ok <= ck_bad;
		rx_cksum_b_ok <= ck_bad;
	endtask : send_msg

	task reject();
		cfg_reject <= 1'b1;
		@(posedge pclk);
		cfg_reject <= 1'b0;
	endtask : reject

	// Transmit answer after a chosen delay
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_done <= 1'b0;
			busy <= 1'b0;
			cnt <= 0;
			drive_tx_msg_count <= 16'sh0000;
			drive_rx_msg_count <= 16'h0000;
		end else begin
			tx_done <= 1'b0;
			if (tx_start) begin
				busy <= 1'b1;
				cnt <= tx_delay;
				drive_tx_msg_count <= drive_tx_msg_count + 16'sh0001;
				drive_rx_msg_count <= drive_rx_msg_count + 16'h0001;
			end else if (busy) begin
				if (cnt == 0) begin
					tx_done <= 1'b1;
					busy <= 1'b0;
				end else begin
					cnt <= cnt - 1;
				end
			end
		end
	end
endmodule : dlch_drive_model

// ### tb/tb_drive_link_command_handshake.sv
`timescale 1ns/1ps
module tb_drive_link_command_handshake;
	localparam logic [6:0] I_LNK = dlch_pkg::IDX_LINK_UP;
	localparam logic [6:0] I_ERR = dlch_pkg::IDX_COMM_ERR;
	localparam logic [6:0] I_CMD = dlch_pkg::IDX_COMMAND;
	localparam logic [6:0] I_TXS = dlch_pkg::IDX_TX_STATUS;
	localparam logic [6:0] I_CLR = dlch_pkg::IDX_COMM_CLR;
	localparam logic [15:0] CFG = dlch_pkg::CMD_CONFIG;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic        rbv, rpar, rfe, rend, cka, ckb, store, txd, rej, txs, fc;
	logic [7:0]  rbyte;
	logic [15:0] txc, last_cmd, r;
	logic        e;
	int          miscompares, n_compared, n_tx, n_store, n;

	dlch_link_cmd #(.TICK_CYCLES(10)) uut (.pclk(pclk), .presetn(presetn),
		.paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_byte_valid(rbv), .rx_byte(rbyte),
		.rx_parity(rpar), .rx_frame_err(rfe), .rx_msg_end(rend),
		.rx_cksum_a_ok(cka), .rx_cksum_b_ok(ckb), .rx_store_en(store),
		.tx_done(txd), .cfg_reject(rej), .tx_start(txs), .tx_command(txc),
		.fault_code_c(fc));
	dlch_drive_model u_drv (.pclk(pclk), .presetn(presetn), .tx_start(txs),
		.rx_byte_valid(rbv), .rx_byte(rbyte), .rx_parity(rpar),
		.rx_frame_err(rfe), .rx_msg_end(rend), .rx_cksum_a_ok(cka),
		.rx_cksum_b_ok(ckb), .tx_done(txd), .cfg_reject(rej));

	always #20 pclk = ~pclk;

	always @(posedge pclk) begin
		if (txs === 1'b1) begin
			n_tx <= n_tx + 1;
			last_cmd <= txc;
		end
		if (store === 1'b1) begin
			n_store <= n_store + 1;
		end
	end

	task end_sim();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim

	task hang(input string what);
		miscompares++;
		$display("wrong value %s expected done seen timeout", what);
		end_sim();
	endtask : hang

	task chk(input string what, input logic [15:0] ex, input logic [15:0] got);
		n_compared++;
		if (got !== ex) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, ex, got);
		end
	endtask : chk

	task apb(input logic w, input logic [6:0] i, input logic [15:0] d,
		output logic [15:0] q, output logic err);
		int k;
		paddr <= {3'h0, i, 2'h0};
		pwrite <= w;
		pwdata <= {16'h0000, d};
		psel <= 1'b1;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) hang("pready");
		q = prdata[15:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	task wr(input logic [6:0] i, input logic [15:0] d);
		apb(1'b1, i, d, r, e);
	endtask : wr

	task rd(input string what, input logic [6:0] i, input logic [15:0] ex);
		apb(1'b0, i, 16'h0000, r, e);
		chk(what, ex, r);
	endtask : rd

	task wait_tx(input int base);
		n = 0;
		while (n_tx == base && n < 40) begin
			@(posedge pclk);
			n++;
		end
		if (n_tx == base) hang("tx_start");
	endtask : wait_tx

	task wait_idle();
		n = 0;
		r = 16'h0001;
		while (r[0] !== 1'b0 && n < 40) begin
			apb(1'b0, I_TXS, 16'h0000, r, e);
			n++;
		end
		if (r[0] !== 1'b0) hang("tx idle");
	endtask : wait_idle

	initial begin
		#400000;
		hang("run");
	end

	initial begin
		pclk = 0;
		presetn = 0;
		{paddr, psel, penable, pwrite, pwdata} = '0;
		pstrb = 4'hf;
		{miscompares, n_compared, n_tx, n_store} = '0;
		last_cmd = 16'h0000;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset state and an unmapped place
		rd("link_up", I_LNK, 16'h0000);
		rd("comm_err", I_ERR, 16'h0000);
		rd("tx_active", I_TXS, 16'h0000);
		rd("command", I_CMD, 16'h0000);
		rd("rx_count", dlch_pkg::IDX_RX_COUNT, 16'h0000);
		rd("timeout", dlch_pkg::IDX_TIMING, 16'h0064);
		rd("scan", dlch_pkg::IDX_SCAN, 16'h0014);
		chk("fault_c", 16'h0001, {15'h0, fc});
		apb(1'b0, 7'h01, 16'h0000, r, e);
		chk("pslverr", 16'h0001, {15'h0, e});
		wr(dlch_pkg::IDX_IN_INT, 16'h0005);
		rd("in_int", dlch_pkg::IDX_IN_INT, 16'h0005);
		// Low byte lane only
		pstrb <= 4'h1;
		wr(dlch_pkg::IDX_IN_INT, 16'h12ab);
		pstrb <= 4'hf;
		rd("in_int_low", dlch_pkg::IDX_IN_INT, 16'h00ab);
		// Configure held while the link is down
		wr(I_CMD, CFG);
		repeat (3) @(posedge pclk);
		rd("held_cfg", I_CMD, CFG);
		chk("tx_count", 16'h0000, 16'(n_tx));
		// Link comes up, held configure goes out
		u_drv.send_msg(1'b0, 1'b0, 1'b0);
		wait_tx(0);
		chk("sent", CFG, last_cmd);
		chk("drive_rx", 16'h0001, u_drv.drive_rx_msg_count);
		chk("fault_c", 16'h0000, {15'h0, fc});
		chk("stored", 16'h0001, 16'(n_store));
		rd("rx_count", dlch_pkg::IDX_RX_COUNT, 16'h0001);
		rd("link_up", I_LNK, 16'h0001);
		rd("command", I_CMD, 16'h0000);
		rd("tx_active", I_TXS, 16'h0001);
		wait_idle();
		// Parity error latches a request that is then dropped
		u_drv.send_msg(1'b1, 1'b0, 1'b0);
		repeat (3) @(posedge pclk);
		rd("comm_err", I_ERR, 16'h0001);
		chk("stored", 16'h0001, 16'(n_store));
		wr(I_CMD, 16'h0008);
		repeat (3) @(posedge pclk);
		rd("held", I_CMD, 16'h0008);
		wr(I_CLR, 16'h0001);
		repeat (3) @(posedge pclk);
		rd("dropped", I_CMD, 16'h0000);
		rd("comm_err", I_ERR, 16'h0000);
		chk("tx_count", 16'h0001, 16'(n_tx));
		// Checksum error latches a configure, sent on clear
		u_drv.send_msg(1'b0, 1'b1, 1'b0);
		repeat (3) @(posedge pclk);
		rd("comm_err", I_ERR, 16'h0001);
		wr(I_CMD, CFG);
		repeat (3) @(posedge pclk);
		rd("held_cfg", I_CMD, CFG);
		wr(I_CLR, 16'h0001);
		wait_tx(1);
		chk("sent", CFG, last_cmd);
		wait_idle();
		// Checked host request starts and clears
		rd("command", I_CMD, 16'h0000);
		rd("tx_active", I_TXS, 16'h0000);
		wr(I_CMD, 16'h0010);
		wait_tx(2);
		chk("sent", 16'h0010, last_cmd);
		rd("command", I_CMD, 16'h0000);
		wait_idle();
		// Configure accepted under configuration errors
		u_drv.reject();
		repeat (2) @(posedge pclk);
		rd("cfg_err", dlch_pkg::IDX_CFG_ERR, 16'h0001);
		wr(I_CMD, CFG);
		wait_tx(3);
		chk("sent", CFG, last_cmd);
		wait_idle();
		rd("cfg_err", dlch_pkg::IDX_CFG_ERR, 16'h0000);
		// Framing error blocks storage and counts
		u_drv.send_msg(1'b0, 1'b0, 1'b1);
		repeat (3) @(posedge pclk);
		rd("comm_err", I_ERR, 16'h0001);
		chk("stored", 16'h0001, 16'(n_store));
		wr(I_CLR, 16'h0001);
		rd("comm_err", I_ERR, 16'h0000);
		// Silence takes the link down
		wr(dlch_pkg::IDX_TIMING, 16'h0003);
		n = 0;
		while (fc !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (fc !== 1'b1) hang("link loss");
		chk("fault_c", 16'h0001, {15'h0, fc});
		rd("link_up", I_LNK, 16'h0000);
		rd("comm_err", I_ERR, 16'h0001);
		chk("drive_tx", 16'h0004, u_drv.drive_tx_msg_count);
		chk("drive_rx", 16'h0004, u_drv.drive_rx_msg_count);
		end_sim();
	end
endmodule : tb_drive_link_command_handshake
